// ### cmc_pkg.sv
package cmc_pkg;

  localparam int CMC_XLEN = 32;

  // Register addresses in the CSR space.
  localparam logic [11:0] CMC_ADDR_JVT = 12'h017;
  localparam logic [11:0] CMC_ADDR_STATUS = 12'h300;
  localparam logic [11:0] CMC_ADDR_ISA = 12'h301;
  localparam logic [11:0] CMC_ADDR_IRQ_MASK = 12'h304;

  // Access operations presented on the CSR port.
  localparam logic [1:0] CMC_OP_READ = 2'h0;
  localparam logic [1:0] CMC_OP_WRITE = 2'h1;
  localparam logic [1:0] CMC_OP_SET = 2'h2;
  localparam logic [1:0] CMC_OP_CLEAR = 2'h3;

  // Privilege encodings.
  localparam logic [1:0] CMC_PRIV_USER = 2'h0;
  localparam logic [1:0] CMC_PRIV_MACHINE = 2'h3;
  localparam logic [1:0] CMC_PRIV_RESET = 2'h3;

  // Jump table base register layout.
  localparam int CMC_JVT_BASE_LSB = 6;
  localparam int CMC_JVT_BASE_W = 26;
  localparam logic [31:0] CMC_JVT_WR_MASK = 32'hFFFFFFC0;
  localparam logic [31:0] CMC_JVT_RESET = 32'h00000000;

  // Machine status word layout.
  localparam int CMC_ST_GIE_BIT = 3;
  localparam int CMC_ST_SAVED_IRQ_ENABLE_BIT = 7;
  localparam int CMC_ST_MPP_LSB = 11;
  localparam int CMC_ST_MPP_MSB = 12;
  localparam int CMC_ST_LOAD_STORE_PRIV_OVERRIDE_BIT = 17;
  localparam int CMC_ST_TW_BIT = 21;
  localparam logic [31:0] CMC_ST_WR_MASK = 32'h00221888;
  localparam logic [31:0] CMC_ST_RESET = 32'h00001800;
  localparam logic [1:0] CMC_MPP_DEFAULT = 2'h0;

  // ISA descriptor layout.
  localparam logic [31:0] CMC_ISA_FIXED = 32'h40900004;
  localparam int CMC_ISA_I_BIT = 8;
  localparam int CMC_ISA_E_BIT = 4;
  localparam int CMC_ISA_M_BIT = 12;

  // Interrupt enable mask layout.
  localparam logic [31:0] CMC_IRQ_WR_MASK = 32'hFFFF0888;
  localparam logic [31:0] CMC_IRQ_RESET = 32'h00000000;

endpackage

// ### cmc_legal_if.sv
interface cmc_legal_if;
  logic [31:0] raw_value;
  logic [31:0] legal_jvt;
  logic [31:0] legal_status;
  logic [31:0] legal_irq_mask;

  modport bank (
    output raw_value,
    input legal_jvt,
    input legal_status,
    input legal_irq_mask
  );

  modport legal (
    input raw_value,
    output legal_jvt,
    output legal_status,
    output legal_irq_mask
  );
endinterface

// ### cmc_csr_legal.sv
module cmc_csr_legal
  import cmc_pkg::*;
(
  cmc_legal_if.legal lif
);

  wire [1:0] raw_mpp = lif.raw_value[CMC_ST_MPP_MSB:CMC_ST_MPP_LSB];
  wire mpp_supported = (raw_mpp == CMC_PRIV_USER) || (raw_mpp == CMC_PRIV_MACHINE);
  wire [1:0] mpp_legal = mpp_supported ? raw_mpp : CMC_MPP_DEFAULT; // [RL4] [RL9]
  wire [31:0] status_masked = lif.raw_value & CMC_ST_WR_MASK; // [RL15] [RL23]

  // The mode bits of the jump table base are dropped here, so they read zero.
  assign lif.legal_jvt = lif.raw_value & CMC_JVT_WR_MASK; // [RL3] [RL8]
  assign lif.legal_irq_mask = lif.raw_value & CMC_IRQ_WR_MASK; // [RL22]

  always_comb begin
    lif.legal_status = status_masked;
    lif.legal_status[CMC_ST_MPP_MSB:CMC_ST_MPP_LSB] = mpp_legal; // [RL9]
  end

endmodule

// ### cmc_csr_bank.sv
// Contract
// RL1: Read-only fields ignore CSR writes and return constants or core-produced values.
// RL2: Read/write fields keep written values unless core operation later updates them.
// RL3: Legalizing fields keep only supported values; zero-only fields always read zero.
// RL4: Unsupported writes to multi-value legalizing fields read back the default value.
// RL5: Legalizing fields without restricted values behave as ordinary read/write fields.
// RL6: Field access class never decides illegal-instruction exceptions for CSR accesses.
// RL7: Jump table base bits 31:6 are writable, 64-byte aligned, reset to zero.
// RL8: Jump table mode bits 5:0 accept writes and always read zero.
// RL9: Prior privilege bits 12:11 hold only user or machine; others read user.
// RL10: Machine trap return sets current privilege to the prior privilege field.
// RL11: With status bit 21 set, user-mode wait-for-interrupt raises illegal instruction immediately.
// RL12: With status bit 17 set, loads and stores use the prior privilege.
// RL13: Trap copies global enable into bit 7; trap return copies it back.
// RL14: Handler software sets global enable bit 3 itself for nested interrupts.
// RL15: Status bits 31, 22, 20, supervisor, extension, endian and reserved read zero.
// RL16: ISA descriptor width code bits 31:30 always read one.
// RL17: ISA descriptor reads one in bits 20, 23, 2; supervisor and others zero.
// RL18: ISA bit 8 for 32-register base, bit 4 for reduced embedded base.
// RL19: ISA bit 12 set only when the multiply/divide option is enabled.
// RL20: Enable mask bits 31:16 are writable and enable fast interrupt lines.
// RL21: Enable mask bits 11, 7, 3 enable external, timer and software lines.
// RL22: Other enable mask bits read zero regardless of writes; register resets zero.
// RL23: Preserve-reserved fields read zero and stay zero whatever software writes.
module cmc_csr_bank
  import cmc_pkg::*;
#(
  parameter bit CODE_SIZE_EXT_OPTION = 1'b1,
  parameter bit RV32E_BASE = 1'b0,
  parameter bit MULTIPLY_EXT_OPTION = 1'b1,
  parameter bit ADV_IRQ_CTRL_OPTION = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic csr_access_in,
  input wire logic [1:0] csr_op_in,
  input wire logic [11:0] csr_addr_in,
  input wire logic [31:0] csr_wdata_in,
  input wire logic trap_take_in,
  input wire logic trap_return_in,
  input wire logic wait_for_irq_instr_in,
  input wire logic [31:0] irq_in,
  output logic [31:0] csr_rdata_out,
  output logic csr_hit_out,
  output logic [1:0] priv_mode_out,
  output logic [1:0] lsu_priv_out,
  output logic wait_illegal_out,
  output logic global_irq_enable_out,
  output logic [31:0] irq_enabled_out
);

  // This bank only serves the configuration without the advanced interrupt controller.
  if (ADV_IRQ_CTRL_OPTION) begin : g_refuse_adv_irq
    $error("cmc_csr_bank supports only the configuration without the advanced interrupt controller");
  end

  // The field layouts below assume a 32-bit word, so a package edited out of shape is refused.
  if (CMC_XLEN != 32) begin : g_refuse_xlen
    $error("cmc_csr_bank serves only a 32-bit register word");
  end
  if (CMC_JVT_BASE_LSB + CMC_JVT_BASE_W != CMC_XLEN) begin : g_refuse_jvt_layout
    $error("cmc_csr_bank needs the jump table base field to end at the top of the word");
  end
  if (CMC_ST_MPP_MSB - CMC_ST_MPP_LSB != 1) begin : g_refuse_mpp_layout
    $error("cmc_csr_bank needs a two-bit prior privilege field");
  end

  cmc_legal_if lif ();

  cmc_csr_legal u_legal (
    .lif(lif)
  );

  logic [CMC_JVT_BASE_W-1:0] jvt_base_reg;
  logic [CMC_JVT_BASE_W-1:0] jvt_base_next;
  logic [1:0] prior_privilege_level_reg;
  logic [1:0] prior_privilege_level_next;
  logic load_store_priv_override_reg;
  logic load_store_priv_override_next;
  logic saved_irq_enable_reg;
  logic saved_irq_enable_next;
  logic global_irq_enable_reg;
  logic global_irq_enable_next;
  logic wait_trap_user_reg;
  logic wait_trap_user_next;
  logic [31:0] irq_mask_reg;
  logic [31:0] irq_mask_next;
  logic [1:0] priv_reg;
  logic [1:0] priv_next;
  logic [31:0] rdata_reg;
  logic hit_reg;
  logic [1:0] lsu_priv_reg;
  logic wait_illegal_reg;
  logic [31:0] irq_enabled_reg;
  logic [31:0] irq_enabled_next;
  logic [31:0] status_value;
  logic [31:0] read_value;

  // Address decode. The jump table base exists only with the code size extension.
  wire hit_jvt = CODE_SIZE_EXT_OPTION && (csr_addr_in == CMC_ADDR_JVT);
  wire hit_status = (csr_addr_in == CMC_ADDR_STATUS);
  wire hit_isa = (csr_addr_in == CMC_ADDR_ISA);
  wire hit_irq_mask = (csr_addr_in == CMC_ADDR_IRQ_MASK);
  wire hit_any = hit_jvt | hit_status | hit_isa | hit_irq_mask;

  // Access class only shapes the stored value; legality of the access is judged upstream.
  wire csr_write = csr_access_in && (csr_op_in != CMC_OP_READ); // [RL6]
  wire write_jvt = csr_write && hit_jvt;
  wire write_status = csr_write && hit_status;
  wire write_irq_mask = csr_write && hit_irq_mask;

  wire [31:0] jvt_value = {jvt_base_reg, {CMC_JVT_BASE_LSB{1'b0}}}; // [RL7] [RL8]

  // The descriptor is a constant of the build, so writes have nothing to land in.
  wire [31:0] isa_i_bit = RV32E_BASE ? 32'h00000000 : (32'h00000001 << CMC_ISA_I_BIT); // [RL18]
  wire [31:0] isa_e_bit = RV32E_BASE ? (32'h00000001 << CMC_ISA_E_BIT) : 32'h00000000; // [RL18]
  wire [31:0] isa_m_bit = MULTIPLY_EXT_OPTION ? (32'h00000001 << CMC_ISA_M_BIT) : 32'h00000000; // [RL19]
  wire [31:0] isa_value = CMC_ISA_FIXED | isa_i_bit | isa_e_bit | isa_m_bit; // [RL1] [RL16] [RL17]

  // Status bits outside the stored fields are never driven, so they read zero.
  always_comb begin
    status_value = 32'h00000000; // [RL15] [RL23]
    status_value[CMC_ST_GIE_BIT] = global_irq_enable_reg;
    status_value[CMC_ST_SAVED_IRQ_ENABLE_BIT] = saved_irq_enable_reg;
    status_value[CMC_ST_MPP_MSB:CMC_ST_MPP_LSB] = prior_privilege_level_reg;
    status_value[CMC_ST_LOAD_STORE_PRIV_OVERRIDE_BIT] = load_store_priv_override_reg;
    status_value[CMC_ST_TW_BIT] = wait_trap_user_reg;
  end

  always_comb begin
    read_value = 32'h00000000;
    if (hit_jvt) begin
      read_value = jvt_value;
    end else if (hit_status) begin
      read_value = status_value;
    end else if (hit_isa) begin
      read_value = isa_value;
    end else if (hit_irq_mask) begin
      read_value = irq_mask_reg; // [RL22]
    end
  end

  // Set and clear operations work on the value that a read would return.
  wire [31:0] set_value = read_value | csr_wdata_in;
  wire [31:0] clear_value = read_value & ~csr_wdata_in;
  wire op_is_write = (csr_op_in == CMC_OP_WRITE);
  wire op_is_set = (csr_op_in == CMC_OP_SET);
  assign lif.raw_value = op_is_write ? csr_wdata_in : (op_is_set ? set_value : clear_value);

  wire [1:0] legal_mpp = lif.legal_status[CMC_ST_MPP_MSB:CMC_ST_MPP_LSB];

  always_comb begin
    jvt_base_next = jvt_base_reg;
    irq_mask_next = irq_mask_reg;
    if (write_jvt) begin
      jvt_base_next = lif.legal_jvt[31:CMC_JVT_BASE_LSB]; // [RL2] [RL7]
    end
    if (write_irq_mask) begin
      irq_mask_next = lif.legal_irq_mask; // [RL20] [RL21] [RL22]
    end
  end

  // A trap or trap return in the same cycle as a status write wins over the write,
  // because the pipeline retires the trap after the CSR instruction is squashed.
  always_comb begin
    prior_privilege_level_next = prior_privilege_level_reg;
    if (trap_take_in) begin
      prior_privilege_level_next = priv_reg;
    end else if (trap_return_in) begin
      prior_privilege_level_next = CMC_PRIV_USER;
    end else if (write_status) begin
      prior_privilege_level_next = legal_mpp; // [RL4] [RL9]
    end
  end

  always_comb begin
    saved_irq_enable_next = saved_irq_enable_reg;
    if (trap_take_in) begin
      saved_irq_enable_next = global_irq_enable_reg; // [RL13]
    end else if (trap_return_in) begin
      saved_irq_enable_next = 1'b1;
    end else if (write_status) begin
      saved_irq_enable_next = lif.legal_status[CMC_ST_SAVED_IRQ_ENABLE_BIT]; // [RL2]
    end
  end

  always_comb begin
    global_irq_enable_next = global_irq_enable_reg;
    if (trap_take_in) begin
      global_irq_enable_next = 1'b0;
    end else if (trap_return_in) begin
      global_irq_enable_next = saved_irq_enable_reg; // [RL13]
    end else if (write_status) begin
      global_irq_enable_next = lif.legal_status[CMC_ST_GIE_BIT]; // [RL2] [RL14]
    end
  end

  always_comb begin
    priv_next = priv_reg;
    if (trap_take_in) begin
      priv_next = CMC_PRIV_MACHINE;
    end else if (trap_return_in) begin
      priv_next = prior_privilege_level_reg; // [RL10]
    end
  end

  // Traps leave the override and the wait trap alone, so a write in a trap cycle still lands there.
  always_comb begin
    load_store_priv_override_next = load_store_priv_override_reg;
    if (write_status) begin
      load_store_priv_override_next = lif.legal_status[CMC_ST_LOAD_STORE_PRIV_OVERRIDE_BIT]; // [RL2]
    end
  end

  always_comb begin
    wait_trap_user_next = wait_trap_user_reg;
    if (write_status) begin
      wait_trap_user_next = lif.legal_status[CMC_ST_TW_BIT]; // [RL5]
    end
  end

  // The load/store privilege follows the state that the next instruction sees.
  wire [1:0] lsu_priv_next = load_store_priv_override_next ? prior_privilege_level_next : priv_next; // [RL12]
  wire wait_illegal_next = wait_for_irq_instr_in && wait_trap_user_reg && (priv_reg == CMC_PRIV_USER); // [RL11]
  wire [31:0] rdata_next = csr_access_in ? read_value : 32'h00000000;
  wire hit_next = csr_access_in && hit_any;

  // Each request line is gated by the enable bit of the same index.
  for (genvar b = 0; b < CMC_XLEN; b++) begin : g_irq_gate
    assign irq_enabled_next[b] = irq_in[b] & irq_mask_reg[b]; // [RL20] [RL21]
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      jvt_base_reg <= CMC_JVT_RESET[31:CMC_JVT_BASE_LSB]; // [RL7]
    end else if (clk_en_in) begin
      jvt_base_reg <= jvt_base_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_mask_reg <= CMC_IRQ_RESET; // [RL22]
    end else if (clk_en_in) begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prior_privilege_level_reg <= CMC_ST_RESET[CMC_ST_MPP_MSB:CMC_ST_MPP_LSB];
    end else if (clk_en_in) begin
      prior_privilege_level_reg <= prior_privilege_level_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      load_store_priv_override_reg <= CMC_ST_RESET[CMC_ST_LOAD_STORE_PRIV_OVERRIDE_BIT];
    end else if (clk_en_in) begin
      load_store_priv_override_reg <= load_store_priv_override_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      saved_irq_enable_reg <= CMC_ST_RESET[CMC_ST_SAVED_IRQ_ENABLE_BIT];
    end else if (clk_en_in) begin
      saved_irq_enable_reg <= saved_irq_enable_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      global_irq_enable_reg <= CMC_ST_RESET[CMC_ST_GIE_BIT];
    end else if (clk_en_in) begin
      global_irq_enable_reg <= global_irq_enable_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_trap_user_reg <= CMC_ST_RESET[CMC_ST_TW_BIT];
    end else if (clk_en_in) begin
      wait_trap_user_reg <= wait_trap_user_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      priv_reg <= CMC_PRIV_RESET;
    end else if (clk_en_in) begin
      priv_reg <= priv_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_reg <= 32'h00000000;
    end else if (clk_en_in) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hit_reg <= 1'b0;
    end else if (clk_en_in) begin
      hit_reg <= hit_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lsu_priv_reg <= CMC_PRIV_RESET;
    end else if (clk_en_in) begin
      lsu_priv_reg <= lsu_priv_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_illegal_reg <= 1'b0;
    end else if (clk_en_in) begin
      wait_illegal_reg <= wait_illegal_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_enabled_reg <= 32'h00000000;
    end else if (clk_en_in) begin
      irq_enabled_reg <= irq_enabled_next;
    end
  end

  assign csr_rdata_out = rdata_reg;
  assign csr_hit_out = hit_reg;
  assign priv_mode_out = priv_reg;
  assign lsu_priv_out = lsu_priv_reg;
  assign wait_illegal_out = wait_illegal_reg;
  assign global_irq_enable_out = global_irq_enable_reg;
  assign irq_enabled_out = irq_enabled_reg;

endmodule

// ### cmc_csr_bank_asserts.sv
module cmc_csr_bank_asserts
  import cmc_pkg::*;
#(
  parameter bit CODE_SIZE_EXT_OPTION = 1'b1,
  parameter bit RV32E_BASE = 1'b0,
  parameter bit MULTIPLY_EXT_OPTION = 1'b1,
  parameter bit ADV_IRQ_CTRL_OPTION = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic csr_access_in,
  input wire logic [1:0] csr_op_in,
  input wire logic [11:0] csr_addr_in,
  input wire logic [31:0] csr_wdata_in,
  input wire logic trap_take_in,
  input wire logic trap_return_in,
  input wire logic wait_for_irq_instr_in,
  input wire logic [31:0] irq_in,
  input wire logic [31:0] csr_rdata_out,
  input wire logic csr_hit_out,
  input wire logic [1:0] priv_mode_out,
  input wire logic [1:0] lsu_priv_out,
  input wire logic wait_illegal_out,
  input wire logic global_irq_enable_out,
  input wire logic [31:0] irq_enabled_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ISA_V = CMC_ISA_FIXED | (RV32E_BASE ? 32'h00000010 : 32'h00000100) |
    (MULTIPLY_EXT_OPTION ? 32'h00001000 : 32'h00000000);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  chk_isa_fixed_value: assert property (
    clk_en_in && csr_access_in && csr_addr_in == CMC_ADDR_ISA |=> csr_hit_out && csr_rdata_out == ISA_V)
    else $error("isa descriptor read wrong");
  chk_status_zero_bits: assert property (
    clk_en_in && csr_access_in && csr_addr_in == CMC_ADDR_STATUS |=> (csr_rdata_out & ~CMC_ST_WR_MASK) == 0)
    else $error("status fixed bits nonzero");
  chk_prior_priv_legal: assert property (
    clk_en_in && csr_access_in && csr_addr_in == CMC_ADDR_STATUS |=> csr_rdata_out[12:11] inside {2'h0, 2'h3})
    else $error("prior privilege illegal");
  chk_mask_zero_bits: assert property (
    clk_en_in && csr_access_in && csr_addr_in == CMC_ADDR_IRQ_MASK |=> (csr_rdata_out & ~CMC_IRQ_WR_MASK) == 0)
    else $error("enable mask fixed bits nonzero");
  chk_jump_mode_zero: assert property (
    CODE_SIZE_EXT_OPTION && clk_en_in && csr_access_in && csr_addr_in == CMC_ADDR_JVT |=> csr_rdata_out[5:0] == 0)
    else $error("jump mode nonzero");
  chk_wait_illegal_cause: assert property (
    $past(clk_en_in) && wait_illegal_out |-> $past(wait_for_irq_instr_in) && $past(priv_mode_out) == CMC_PRIV_USER)
    else $error("wait illegal without user wait");
  chk_trap_entry: assert property (
    clk_en_in && trap_take_in |=> priv_mode_out == CMC_PRIV_MACHINE && !global_irq_enable_out)
    else $error("trap entry state wrong");
  chk_irq_gating: assert property (
    $past(clk_en_in) |-> (irq_enabled_out & ~($past(irq_in) & CMC_IRQ_WR_MASK)) == 0)
    else $error("irq enabled outside mask");
  cov_trap: cover property (trap_take_in ##1 trap_return_in);
  cov_wait_illegal: cover property (wait_illegal_out);
  cov_user_lsu: cover property (lsu_priv_out == CMC_PRIV_USER);
endmodule

bind cmc_csr_bank cmc_csr_bank_asserts #(.CODE_SIZE_EXT_OPTION(CODE_SIZE_EXT_OPTION), .RV32E_BASE(RV32E_BASE),
  .MULTIPLY_EXT_OPTION(MULTIPLY_EXT_OPTION), .ADV_IRQ_CTRL_OPTION(ADV_IRQ_CTRL_OPTION)) cmc_csr_bank_asserts_i (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in), .csr_access_in(csr_access_in),
  .csr_op_in(csr_op_in), .csr_addr_in(csr_addr_in), .csr_wdata_in(csr_wdata_in), .trap_take_in(trap_take_in),
  .trap_return_in(trap_return_in), .wait_for_irq_instr_in(wait_for_irq_instr_in), .irq_in(irq_in),
  .csr_rdata_out(csr_rdata_out), .csr_hit_out(csr_hit_out), .priv_mode_out(priv_mode_out),
  .lsu_priv_out(lsu_priv_out), .wait_illegal_out(wait_illegal_out),
  .global_irq_enable_out(global_irq_enable_out), .irq_enabled_out(irq_enabled_out));

// ### cmc_csr_bank_tb_top.sv
module cmc_csr_bank_tb_top;
  import cmc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ISA_V = CMC_ISA_FIXED | 32'h00000100 | 32'h00001000;
  logic sys_clk_in = 1'b0;
  logic resetn_n = 1'b0;
  logic clk_en = 1'b1;
  logic csr_access = 1'b0;
  logic [1:0] csr_op = 2'h0;
  logic [11:0] csr_addr = 12'h000;
  logic [31:0] csr_wdata = 32'h00000000;
  logic [2:0] ev = 3'h0;
  logic [31:0] irq = 32'h00000000;
  logic [31:0] rdata, irq_en;
  logic hit, wait_ill, gie;
  logic [1:0] priv, lsu_priv;
  logic [11:0] ad [4] = '{CMC_ADDR_STATUS, CMC_ADDR_IRQ_MASK, CMC_ADDR_JVT, CMC_ADDR_ISA};
  logic [31:0] wm [3] = '{CMC_ST_WR_MASK, CMC_IRQ_WR_MASK, CMC_JVT_WR_MASK};
  logic [31:0] m [3] = '{CMC_ST_RESET, CMC_IRQ_RESET, CMC_JVT_RESET};
  logic [1:0] pr = CMC_PRIV_RESET;
  int num_errors = 0;
  int cmp_count = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;

  cmc_csr_bank cmc_csr_bank_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_n), .clk_en_in(clk_en),
    .csr_access_in(csr_access), .csr_op_in(csr_op), .csr_addr_in(csr_addr), .csr_wdata_in(csr_wdata),
    .trap_take_in(ev[0]), .trap_return_in(ev[1]), .wait_for_irq_instr_in(ev[2]), .irq_in(irq),
    .csr_rdata_out(rdata), .csr_hit_out(hit), .priv_mode_out(priv), .lsu_priv_out(lsu_priv),
    .wait_illegal_out(wait_ill), .global_irq_enable_out(gie), .irq_enabled_out(irq_en));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] nxt(input int i, input logic [1:0] op, input logic [31:0] o, input logic [31:0] w);
    logic [31:0] n;
    if (op == CMC_OP_READ) return o;
    n = (op == CMC_OP_WRITE) ? w : (op == CMC_OP_SET) ? (o | w) : (o & ~w);
    n = n & wm[i];
    if (i == 0 && (n[12:11] == 2'h1 || n[12:11] == 2'h2)) n[12:11] = CMC_MPP_DEFAULT;
    return n;
  endfunction

  // Index 4 picks an unmapped address; reads return the value held before a same-cycle write.
  task automatic acc(input int i, input logic [1:0] op, input logic [31:0] w);
    logic [31:0] e;
    e = (i < 3) ? m[i] : (i == 3) ? ISA_V : 32'h00000000;
    csr_access = 1'b1;
    csr_op = op;
    csr_addr = (i < 4) ? ad[i] : {2'h1, 10'($urandom())};
    csr_wdata = w;
    irq = $urandom();
    @(posedge sys_clk_in);
    #1;
    chk("rdata", rdata, e);
    chk("hit", 32'(hit), 32'(i < 4));
    chk("irq_en", irq_en, irq & m[1]);
    if (i < 3) m[i] = nxt(i, op, m[i], w);
    chk("gie", 32'(gie), 32'(m[0][3]));
    chk("lsu_priv", 32'(lsu_priv), 32'(m[0][17] ? m[0][12:11] : pr));
  endtask

  task automatic idle();
    csr_access = 1'b0;
    ev = 3'h0;
    @(posedge sys_clk_in);
    #1;
  endtask

  task automatic pulse(input int k);
    ev = 3'h1 << k;
    @(posedge sys_clk_in);
    #1;
  endtask

  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'h0034));
    repeat (10) @(posedge sys_clk_in);
    #1;
    resetn_n = 1'b1;
    chk("priv_reset", 32'(priv), 32'(CMC_PRIV_RESET));
    for (int i = 0; i < 5; i++) acc(i, CMC_OP_READ, 32'h00000000);
    for (int i = 0; i < 3; i++) acc(i, CMC_OP_WRITE, 32'hFFFFFFFF);
    for (int i = 0; i < 3; i++) acc(i, CMC_OP_CLEAR, 32'hFFFFFFFF);
    acc(3, CMC_OP_WRITE, 32'h00000000);
    for (int v = 0; v < 5; v++) acc(0, CMC_OP_WRITE, (v % 4) << 11);
    acc(0, CMC_OP_WRITE, 32'h00000088);
    idle();
    pulse(1);
    pr = CMC_PRIV_USER;
    m[0] = 32'h00000088;
    chk("priv_ret", 32'(priv), 32'(CMC_PRIV_USER));
    chk("gie_ret", 32'(gie), 32'h1);
    idle();
    acc(0, CMC_OP_WRITE, 32'h00200008);
    idle();
    pulse(2);
    chk("wait_ill", 32'(wait_ill), 32'h1);
    idle();
    chk("wait_ill_end", 32'(wait_ill), 32'h0);
    pulse(0);
    pr = CMC_PRIV_MACHINE;
    m[0] = 32'h00200080;
    chk("priv_trap", 32'(priv), 32'(CMC_PRIV_MACHINE));
    chk("gie_trap", 32'(gie), 32'h0);
    idle();
    acc(0, CMC_OP_READ, 32'h00000000);
    idle();
    pulse(2);
    chk("wait_mach", 32'(wait_ill), 32'h0);
    idle();
    // A frozen cycle must drop both the status write and the trap.
    clk_en = 1'b0;
    csr_access = 1'b1;
    csr_op = CMC_OP_WRITE;
    csr_addr = CMC_ADDR_STATUS;
    csr_wdata = 32'hFFFFFFFF;
    pulse(0);
    chk("frozen_hit", 32'(hit), 32'h0);
    chk("frozen_gie", 32'(gie), 32'h0);
    clk_en = 1'b1;
    idle();
    acc(0, CMC_OP_READ, 32'h00000000);
    repeat (400) acc($urandom() % 5, 2'($urandom()), $urandom());
    idle();
    conclude();
  end
endmodule
